// File: shared/adcts_pkg.sv
// Package: register map, fields and encodings of the converter trigger/scan control
package adcts_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADCTS_CTRL_ADDR   = 8'h00;
    localparam logic [7:0] ADCTS_TRIG_ADDR   = 8'h04;
    localparam logic [7:0] ADCTS_STAT_ADDR   = 8'h08;
    localparam logic [7:0] ADCTS_IRQS_ADDR   = 8'h0C;
    localparam logic [7:0] ADCTS_IRQM_ADDR   = 8'h10;
    localparam logic [7:0] ADCTS_RES_ADDR    = 8'h20;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_SCAN_BIT  = 1;
    localparam int CTRL_SEL_LSB   = 4;
    localparam int CTRL_SEL_W     = 3;
    localparam int CTRL_TMODE_LSB = 8;
    localparam int CTRL_TMODE_W   = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK  = 32'h0000_0373;

    // Interrupt status bits
    localparam int IRQ_DONE_BIT  = 0;
    localparam int IRQ_ABORT_BIT = 1;
    localparam int IRQ_MULTI_BIT = 2;
    localparam int IRQ_W         = 3;

    // ------------------------------------------------------------
    // Dimensions and timing
    // ------------------------------------------------------------
    localparam int NCH      = 8;
    localparam int NTRIG    = 4;
    localparam int RES_W    = 10;
    localparam int CONV_NS  = 1000;
    localparam int CLK_NS   = 20;
    localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W    = 7;

    typedef enum logic [1:0] {
        ADCTS_TRIG_SELF,
        ADCTS_TRIG_TIMER,
        ADCTS_TRIG_EXT,
        ADCTS_TRIG_RSVD
    } adcts_tmode_t;

    typedef enum {
        ADCTS_IDLE,
        ADCTS_WAIT,
        ADCTS_CONV
    } adcts_state_t;

endpackage

// File: src/adcts_trig_arb.sv
// Trigger arbiter: lowest-numbered of coincident triggers wins
`timescale 1ns/1ps
module adcts_trig_arb
    import adcts_pkg::*;
(
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // Trigger requests, one per lower input
    input  wire logic [NTRIG-1:0]       req,
    // Arbitration result
    output logic                        hit,
    output logic [1:0]                  idx,
    output logic                        multi
);
    function automatic logic [1:0] lowest(input logic [NTRIG-1:0] v);
        lowest = 2'h0;
        for (int i = NTRIG - 1; i >= 0; i--)
            if (v[i])
                lowest = i[1:0];
    endfunction

    logic       next_hit;
    logic [1:0] next_idx;
    logic       next_multi;

    always_comb
    begin
        next_hit   = |req;
        next_idx   = lowest(req);
        next_multi = (req & (req - 4'h1)) != 4'h0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hit   <= 1'b0;
            idx   <= 2'h0;
            multi <= 1'b0;
        end
        else
        begin
            hit   <= next_hit;
            idx   <= next_idx;
            multi <= next_multi;
        end
    end
endmodule

// File: src/adcts_sync.sv
// Two-flop synchroniser with rising-edge detect for external pins
`timescale 1ns/1ps
module adcts_sync
    import adcts_pkg::*;
(
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Raw pins
    input  wire logic [NTRIG-1:0]   pin,
    // Rising edges, one cycle each
    output logic [NTRIG-1:0]        rise
);
    logic [NTRIG-1:0] s1;
    logic [NTRIG-1:0] s2;
    logic [NTRIG-1:0] s3;
    logic [NTRIG-1:0] next_rise;

    always_comb
    begin
        next_rise = s2 & ~s3;
    end

    // First stage feeds only the second one
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1   <= 4'h0;
            s2   <= 4'h0;
            s3   <= 4'h0;
            rise <= 4'h0;
        end
        else
        begin
            s1   <= pin;
            s2   <= s1;
            s3   <= s2;
            rise <= next_rise;
        end
    end
endmodule

// File: src/adcts_ctrl.sv
// Converter trigger, scan and interrupt control with APB registers
`timescale 1ns/1ps
module adcts_ctrl
    import adcts_pkg::*;
(
    // APB slave
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Trigger sources
    input  wire logic                       timer0_compare_irq,
    input  wire logic [NTRIG-1:0]           ext_conv_trigger,
    // Converter core
    output logic                            core_start,
    output logic [2:0]                      core_channel,
    input  wire logic [RES_W-1:0]           core_data,
    // Interrupt
    output logic                            conversion_done_irq
);
    // ------------------------------------------------------------
    // Trigger conditioning
    // ------------------------------------------------------------
    logic [NTRIG-1:0] ext_rise;
    logic [NTRIG-1:0] trig_req;
    logic             arb_hit;
    logic [1:0]       arb_idx;
    logic             arb_multi;

    adcts_sync u_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (ext_conv_trigger),
        .rise    (ext_rise)
    );

    logic [31:0]      ctrl;
    logic [NTRIG-1:0] timer_ch;
    adcts_tmode_t     tmode;
    logic             scan;
    logic [2:0]       sel;
    logic             en;

    always_comb
    begin
        tmode = adcts_tmode_t'(ctrl[CTRL_TMODE_LSB +: CTRL_TMODE_W]);
        scan  = ctrl[CTRL_SCAN_BIT];
        sel   = ctrl[CTRL_SEL_LSB +: CTRL_SEL_W];
        en    = ctrl[CTRL_EN_BIT];
        case (tmode)
            ADCTS_TRIG_TIMER: trig_req = timer0_compare_irq ? timer_ch : 4'h0;
            ADCTS_TRIG_EXT:   trig_req = ext_rise;
            default:          trig_req = 4'h0;
        endcase
    end

    adcts_trig_arb u_arb
    (
        .pclk    (pclk),
        .presetn (presetn),
        .req     (en ? trig_req : 4'h0),
        .hit     (arb_hit),
        .idx     (arb_idx),
        .multi   (arb_multi)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    adcts_state_t     state;
    adcts_state_t     next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic [2:0]       ch;
    logic [2:0]       next_ch;
    logic [2:0]       done_n;
    logic [2:0]       next_done_n;
    logic             poison;
    logic             next_poison;
    logic             ev_done;
    logic             ev_abort;
    logic             ev_multi;
    logic             next_start;
    logic             wr_en;
    logic [RES_W-1:0] res [NCH];
    logic [NCH-1:0]   valid;
    logic [NCH-1:0]   next_valid;
    logic             triggered;

    always_comb
    begin
        triggered   = tmode == ADCTS_TRIG_TIMER || tmode == ADCTS_TRIG_EXT;
        next_state  = state;
        next_cnt    = cnt;
        next_ch     = ch;
        next_done_n = done_n;
        next_poison = poison;
        next_valid  = valid;
        next_start  = 1'b0;
        ev_done     = 1'b0;
        ev_abort    = 1'b0;
        ev_multi    = 1'b0;
        wr_en       = 1'b0;
        if (!en)
        begin
            next_state  = ADCTS_IDLE;
            next_done_n = 3'h0;
            next_poison = 1'b0;
        end
        else
        begin
            case (state)
                ADCTS_IDLE:
                begin
                    next_done_n = 3'h0;
                    next_poison = 1'b0;
                    next_ch     = scan ? 3'h0 : sel;
                    if (triggered)
                        next_state = ADCTS_WAIT;
                    else
                    begin
                        next_state = ADCTS_CONV;
                        next_cnt   = CNT_W'(CONV_CYC);
                        next_start = 1'b1;
                    end
                end
                ADCTS_WAIT, ADCTS_CONV:
                begin
                    if (triggered && arb_hit)
                    begin
                        if (state == ADCTS_CONV)
                        begin
                            ev_abort           = 1'b1;
                            next_valid[ch]     = 1'b0;
                        end
                        if (arb_multi)
                        begin
                            ev_multi    = 1'b1;
                            next_poison = 1'b1;
                        end
                        next_ch    = {1'b0, arb_idx};
                        next_state = ADCTS_CONV;
                        next_cnt   = CNT_W'(CONV_CYC);
                        next_start = 1'b1;
                    end
                    else if (state == ADCTS_CONV && cnt == CNT_W'(1))
                    begin
                        wr_en          = 1'b1;
                        next_valid[ch] = 1'b1;
                        next_done_n    = done_n + 3'h1;
                        next_state     = triggered ? ADCTS_WAIT : ADCTS_CONV;
                        if (!triggered)
                        begin
                            next_cnt   = CNT_W'(CONV_CYC);
                            next_start = 1'b1;
                            next_ch    = (scan && ch < sel) ? ch + 3'h1 : (scan ? 3'h0 : sel);
                            ev_done    = !scan || ch == sel;
                        end
                        else
                        begin
                            ev_done     = done_n == sel && !poison;
                            next_done_n = (done_n == sel) ? 3'h0 : done_n + 3'h1;
                            next_poison = (done_n == sel) ? 1'b0 : poison;
                        end
                    end
                    else if (state == ADCTS_CONV)
                        next_cnt = cnt - CNT_W'(1);
                end
                default: next_state = ADCTS_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state        <= ADCTS_IDLE;
            cnt          <= '0;
            ch           <= 3'h0;
            done_n       <= 3'h0;
            poison       <= 1'b0;
            valid        <= 8'h00;
            core_start   <= 1'b0;
            core_channel <= 3'h0;
            for (int i = 0; i < NCH; i++)
                res[i] <= '0;
        end
        else
        begin
            state        <= next_state;
            cnt          <= next_cnt;
            ch           <= next_ch;
            done_n       <= next_done_n;
            poison       <= next_poison;
            valid        <= next_valid;
            core_start   <= next_start;
            core_channel <= next_ch;
            if (wr_en)
                res[ch] <= core_data;
        end
    end

    // ------------------------------------------------------------
    // Registers and interrupt
    // ------------------------------------------------------------
    // Access completes in one cycle; no wait states are ever inserted
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] next_stat;
    logic [IRQ_W-1:0] next_mask;
    logic [IRQ_W-1:0] ev_vec;
    logic [31:0]      next_ctrl;
    logic [NTRIG-1:0] next_timer_ch;
    logic [31:0]      next_prdata;
    logic             next_slverr;
    logic             acc;
    logic             wr;

    always_comb
    begin
        acc           = psel && penable;
        wr            = acc && pwrite;
        next_ctrl     = ctrl;
        next_timer_ch = timer_ch;
        next_mask     = irq_mask;
        next_prdata   = 32'h0000_0000;
        ev_vec        = {ev_multi, ev_abort, ev_done};
        next_stat     = irq_stat;
        if (wr && paddr == ADCTS_IRQS_ADDR)
            next_stat = next_stat & ~pwdata[IRQ_W-1:0];
        // Set wins over a clear in the same cycle
        next_stat = next_stat | ev_vec;
        if (psel && !penable)
        begin
            case (paddr)
                ADCTS_CTRL_ADDR: next_prdata = ctrl;
                ADCTS_TRIG_ADDR: next_prdata = {28'h0, timer_ch};
                ADCTS_STAT_ADDR: next_prdata = {16'h0, valid, 1'b0, ch, 2'h0, 2'(state)};
                ADCTS_IRQS_ADDR: next_prdata = {29'h0, irq_stat};
                ADCTS_IRQM_ADDR: next_prdata = {29'h0, irq_mask};
                default:
                begin
                    if (is_res(paddr))
                        next_prdata = {22'h0, res[paddr[4:2]]};
                    else
                        next_prdata = 32'h0000_0000;
                end
            endcase
        end
        else if (acc)
            next_prdata = prdata;
        next_slverr = psel && !penable && next_slverr_setup(paddr);
        if (wr)
        begin
            case (paddr)
                ADCTS_CTRL_ADDR: next_ctrl     = pwdata & CTRL_MASK;
                ADCTS_TRIG_ADDR: next_timer_ch = pwdata[NTRIG-1:0];
                ADCTS_IRQM_ADDR: next_mask     = pwdata[IRQ_W-1:0];
                default:         next_ctrl     = ctrl;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl                <= CTRL_RESET;
            timer_ch            <= 4'h0;
            irq_stat            <= '0;
            irq_mask            <= '0;
            prdata              <= 32'h0000_0000;
            pready              <= 1'b0;
            pslverr             <= 1'b0;
            conversion_done_irq <= 1'b0;
        end
        else
        begin
            ctrl                <= next_ctrl;
            timer_ch            <= next_timer_ch;
            irq_stat            <= next_stat;
            irq_mask            <= next_mask;
            prdata              <= next_prdata;
            pready              <= psel && !penable;
            pslverr             <= next_slverr;
            conversion_done_irq <= |(next_stat & next_mask);
        end
    end

    function automatic logic is_res(input logic [7:0] a);
        is_res = a[7:5] == ADCTS_RES_ADDR[7:5] && a[1:0] == 2'h0;
    endfunction

    function automatic logic next_slverr_setup(input logic [7:0] a);
        next_slverr_setup = a > ADCTS_IRQM_ADDR && !is_res(a);
    endfunction
endmodule

// File: tb/adcts_partner.sv
// Partner model: timer 0 compare unit and external trigger pins
`timescale 1ns/1ps
module adcts_partner
    import adcts_pkg::*;
(
    // Clock
    input  wire logic                  pclk,
    // Trigger outputs
    output logic                       timer0_compare_irq,
    output logic [adcts_pkg::NTRIG-1:0] ext_conv_trigger
);
    import adcts_pkg::*;

    initial
    begin
        timer0_compare_irq = 1'b0;
        ext_conv_trigger   = '0;
    end

    // ------------------------------------------------------------
    // Timer compare match
    // ------------------------------------------------------------
    // One compare match a call: timer0_compare_irq pulses high for a single cycle
    task automatic fire_timer();
        @(posedge pclk);
        timer0_compare_irq <= 1'b1;
        @(posedge pclk);
        timer0_compare_irq <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // External trigger pins
    // ------------------------------------------------------------
    // Pins keep their function; held several cycles so the sync sees the edge
    task automatic fire_ext(input logic [NTRIG-1:0] m);
        @(posedge pclk);
        ext_conv_trigger <= m;
        repeat (6) @(posedge pclk);
        ext_conv_trigger <= '0;
    endtask
endmodule

// File: tb/adcts_ctrl_properties.sv
// Checker: port-level properties of the converter trigger/scan control
`timescale 1ns/1ps
module adcts_ctrl_properties
    import adcts_pkg::*;
(
    // APB slave
    input wire logic                         pclk,
    input wire logic                         presetn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [7:0]                   paddr,
    input wire logic [31:0]                  pwdata,
    input wire logic [31:0]                  prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    // Triggers, core, interrupt
    input wire logic                         timer0_compare_irq,
    input wire logic [adcts_pkg::NTRIG-1:0]  ext_conv_trigger,
    input wire logic                         core_start,
    input wire logic [2:0]                   core_channel,
    input wire logic [adcts_pkg::RES_W-1:0]  core_data,
    input wire logic                         conversion_done_irq
);
    import adcts_pkg::*;

    // ------------------------------------------------------------
    // Shadow of software settings
    // ------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [3:0]  tmask_q;
    logic [3:0]  wr_age;
    logic        wr_acc;
    logic [1:0]  tm;

    assign wr_acc = psel && penable && pwrite && pready;
    assign tm     = ctrl_q[9:8];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q  <= CTRL_RESET;
            tmask_q <= 4'h0;
            wr_age  <= 4'hF;
        end
        else
        begin
            if (wr_acc && paddr == ADCTS_CTRL_ADDR)
                ctrl_q <= pwdata & CTRL_MASK;
            if (wr_acc && paddr == ADCTS_TRIG_ADDR)
                tmask_q <= pwdata[3:0];
            wr_age <= wr_acc ? 4'h0 : ((wr_age == 4'hF) ? wr_age : wr_age + 4'h1);
        end
    end

    function automatic logic [2:0] low4(input logic [3:0] m);
        return m[0] ? 3'h0 : (m[1] ? 3'h1 : (m[2] ? 3'h2 : 3'h3));
    endfunction

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_PREADY_ONE: assert property ((psel && !penable) |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    AST_PREADY_ACCESS: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_START_PULSE: assert property (core_start |=> !core_start)
        else $error("core_start longer than one cycle");
    AST_SELF_SELECT: assert property (core_start && ctrl_q[0] && tm == ADCTS_TRIG_SELF
        && !ctrl_q[1] |-> core_channel == ctrl_q[6:4])
        else $error("select mode converts wrong channel");
    AST_SELF_SCAN: assert property (core_start && ctrl_q[0] && tm == ADCTS_TRIG_SELF
        && ctrl_q[1] |-> core_channel <= ctrl_q[6:4])
        else $error("scan passes the select field");
    AST_TRIG_LOWER: assert property (core_start && ctrl_q[0]
        && tm != ADCTS_TRIG_SELF |-> !core_channel[2])
        else $error("triggered conversion on upper input");
    AST_TIMER_START: assert property (timer0_compare_irq && ctrl_q[0]
        && tm == ADCTS_TRIG_TIMER && tmask_q != 4'h0
        |-> ##[1:4] (core_start && core_channel == low4(tmask_q)))
        else $error("timer compare did not start lowest input");
    AST_EXT_START: assert property (ctrl_q[0] && tm == ADCTS_TRIG_EXT
        && (ext_conv_trigger & ~$past(ext_conv_trigger)) != 4'h0 |-> ##[2:8] core_start)
        else $error("external edge did not start conversion");
    AST_IRQ_FALL: assert property ($fell(conversion_done_irq) |-> wr_age <= 4'h3)
        else $error("done interrupt dropped without a write");

    cover property (pslverr);
    cover property ($rose(conversion_done_irq));
    cover property (core_start && tm == ADCTS_TRIG_EXT);
endmodule

bind adcts_ctrl adcts_ctrl_properties u_props (
    .pclk (pclk), .presetn (presetn), .psel (psel), .penable (penable),
    .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .prdata (prdata),
    .pready (pready), .pslverr (pslverr), .timer0_compare_irq (timer0_compare_irq),
    .ext_conv_trigger (ext_conv_trigger), .core_start (core_start),
    .core_channel (core_channel), .core_data (core_data),
    .conversion_done_irq (conversion_done_irq)
);

// File: tb/testbench.sv
// Testbench: APB master, converter core stand-in and trigger scenarios
`timescale 1ns/1ps
module testbench;
    import adcts_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic             pclk    = 1'b0;
    logic             presetn = 1'b0;
    logic             psel    = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite  = 1'b0;
    logic [7:0]       paddr   = 8'h00;
    logic [31:0]      pwdata  = 32'h0;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             tirq;
    logic [NTRIG-1:0] ext;
    logic             core_start;
    logic [2:0]       core_channel;
    logic [RES_W-1:0] core_data = '0;
    logic             irq;
    logic [6:0]       base    = 7'h00;
    logic [2:0]       chq[$];
    logic [31:0]      q;
    logic             er;
    logic [2:0]       sel;
    int               num_errors = 0;
    int               tests_run  = 0;
    int               cyc        = 0;

    initial
    begin
        forever #10 pclk = ~pclk;
    end

    adcts_ctrl dut (
        .pclk (pclk), .presetn (presetn), .psel (psel), .penable (penable),
        .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .prdata (prdata),
        .pready (pready), .pslverr (pslverr), .timer0_compare_irq (tirq),
        .ext_conv_trigger (ext), .core_start (core_start),
        .core_channel (core_channel), .core_data (core_data),
        .conversion_done_irq (irq)
    );
    adcts_partner u_part (.pclk (pclk), .timer0_compare_irq (tirq), .ext_conv_trigger (ext));

    // Core stand-in: result depends on channel so misrouting shows up
    always @(posedge pclk)
    begin
        core_data <= {base, core_channel};
        if (core_start === 1'b1)
            chq.push_back(core_channel);
        cyc++;
        if (cyc == 30000)
        begin
            num_errors++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] dval(input logic [2:0] c);
        return {22'h0, base, c};
    endfunction
    function automatic logic [7:0] resa(input logic [2:0] c);
        return ADCTS_RES_ADDR + {3'h0, c, 2'h0};
    endfunction
    function automatic logic [31:0] cw(input logic [2:0] s, input logic sc,
                                       input adcts_tmode_t m);
        return {22'h0, m, 1'b0, s, 2'h0, sc, 1'b1};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, er);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, q, er);
        chk(nm, e, q);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400)
        begin
            @(posedge pclk);
            n++;
        end
        chk("done_irq", 32'h1, {31'h0, irq});
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(69));
        base = 7'($urandom());
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc("ctrl_rst", ADCTS_CTRL_ADDR, CTRL_RESET);
        rdc("irqs_rst", ADCTS_IRQS_ADDR, 32'h0);
        rdc("irqm_rst", ADCTS_IRQM_ADDR, 32'h0);
        rdc("stat_rst", ADCTS_STAT_ADDR, 32'h0);
        wr(8'h40, 32'hFFFF_FFFF);
        apb(1'b0, 8'h40, 32'h0, q, er);
        chk("unmapped_data", 32'h0, q);
        chk("unmapped_err", 32'h1, {31'h0, er});
        // Self trigger: top input, random select, scan on the third pass only
        wr(ADCTS_IRQM_ADDR, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            sel = (i == 0) ? 3'h7 : 3'($urandom_range(7, 0));
            wr(ADCTS_CTRL_ADDR, 32'h0);
            repeat (CONV_CYC) @(posedge pclk);
            wr(ADCTS_IRQS_ADDR, 32'h7);
            wr(ADCTS_CTRL_ADDR, cw(sel, i == 2, ADCTS_TRIG_SELF));
            rdc("ctrl", ADCTS_CTRL_ADDR, cw(sel, i == 2, ADCTS_TRIG_SELF) & CTRL_MASK);
            wait_irq();
            for (int c = 0; c < 8; c++)
                if (c == sel || (i == 2 && c < sel))
                    rdc("result", resa(3'(c)), dval(3'(c)));
        end
        // Masking keeps the line low, status stays sticky until W1C
        wr(ADCTS_IRQM_ADDR, 32'h0);
        repeat (CONV_CYC + 10) @(posedge pclk);
        chk("masked_irq", 32'h0, {31'h0, irq});
        wr(ADCTS_CTRL_ADDR, 32'h0);
        repeat (CONV_CYC) @(posedge pclk);
        rdc("irqs_sticky", ADCTS_IRQS_ADDR, 32'h1);
        wr(ADCTS_IRQS_ADDR, 32'h7);
        rdc("irqs_clear", ADCTS_IRQS_ADDR, 32'h0);
        wr(ADCTS_IRQM_ADDR, 32'h1);
        // Timer: coincident triggers on inputs 1 and 2
        wr(ADCTS_TRIG_ADDR, 32'h6);
        wr(ADCTS_CTRL_ADDR, cw(3'h0, 1'b0, ADCTS_TRIG_TIMER));
        chq.delete();
        u_part.fire_timer();
        repeat (CONV_CYC + 20) @(posedge pclk);
        chk("coincident_chan", 32'h1, {29'h0, chq[0]});
        rdc("coincident_irqs", ADCTS_IRQS_ADDR, 32'h4);
        // Timer: retrigger mid-conversion restarts it
        wr(ADCTS_IRQS_ADDR, 32'h7);
        wr(ADCTS_TRIG_ADDR, 32'h1);
        chq.delete();
        u_part.fire_timer();
        repeat (10) @(posedge pclk);
        u_part.fire_timer();
        wait_irq();
        chk("restarts", 32'h2, 32'(chq.size()));
        rdc("abort_irqs", ADCTS_IRQS_ADDR, 32'h3);
        rdc("timer_res", resa(3'h0), dval(3'h0));
        // External scan: two triggers convert in arrival order
        wr(ADCTS_CTRL_ADDR, 32'h0);
        repeat (CONV_CYC) @(posedge pclk);
        wr(ADCTS_IRQS_ADDR, 32'h7);
        wr(ADCTS_CTRL_ADDR, cw(3'h1, 1'b1, ADCTS_TRIG_EXT));
        chq.delete();
        u_part.fire_ext(4'h4);
        repeat (CONV_CYC + 10) @(posedge pclk);
        u_part.fire_ext(4'h1);
        wait_irq();
        chk("order_first", 32'h2, {29'h0, chq[0]});
        chk("order_second", 32'h0, {29'h0, chq[1]});
        rdc("ext_res2", resa(3'h2), dval(3'h2));
        rdc("ext_res0", resa(3'h0), dval(3'h0));
        wrap_up();
    end
endmodule
